// File: uart_enhanced_flow_config_bench.sv
// Bench for the quad UART configuration port with both ends joined.
// Assumes the host end runs set-up sequences and both ends share clk_i.
module uart_enhanced_flow_config_bench
	import uefc_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;

	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic cmd_valid = 1'b0;
	uefc_op_t cmd_op = OP_READ;
	logic [1:0] cmd_chan = 2'h0;
	logic [2:0] cmd_addr = 3'h0;
	logic [15:0] cmd_data = 16'h0000;
	logic cmd_ready, done, err, last_err;
	logic [7:0] rdata, last_rd, v;
	logic [3:0] rx_valid = 4'h0, rx_timeout = 4'h0, cts_n = 4'h0;
	logic [3:0][7:0] rx_char = '0;
	logic [3:0][6:0] rx_level = '0, tx_space = '0, rx_trig, tx_trig;
	logic [3:0] rts_n, tx_halt, special;
	logic [3:0][3:0] sw_mode;
	logic [3:0][15:0] baud;
	logic [15:0] dv [4];
	logic [6:0] lv [7] = '{7'd40, 7'd39, 7'd20, 7'd8, 7'd20, 7'd39, 7'd40};
	logic rs [7] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
	int error_cnt = 0, check_count = 0;

	// Clock
	always #5 clk_i = ~clk_i;

	// Both ends and the bus checker
	uefc_if bus_if ();
	uefc_host uefc_host_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus(bus_if.host),
		.cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_op_i(cmd_op),
		.cmd_chan_i(cmd_chan), .cmd_addr_i(cmd_addr), .cmd_data_i(cmd_data),
		.done_o(done), .err_o(err), .rdata_o(rdata));
	uefc_dev uefc_dev_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus(bus_if.dev),
		.rx_valid_i(rx_valid), .rx_char_i(rx_char), .rx_level_i(rx_level),
		.tx_space_i(tx_space), .rx_timeout_i(rx_timeout), .cts_n_i(cts_n),
		.rts_n_o(rts_n), .tx_halt_o(tx_halt), .special_char_o(special),
		.sw_flow_mode_o(sw_mode), .baud_divisor_o(baud), .rx_trig_o(rx_trig),
		.tx_trig_o(tx_trig));
	uefc_properties uefc_properties_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.cs_n(bus_if.cs_n), .addr(bus_if.addr), .wr_n(bus_if.wr_n), .rd_n(bus_if.rd_n),
		.host_d(bus_if.host_d), .host_oe(bus_if.host_oe), .dev_d(bus_if.dev_d),
		.dev_oe(bus_if.dev_oe), .bus_d(bus_if.bus_d));

	task automatic idle(input int n);
		repeat (n) @(posedge clk_i);
	endtask : idle

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e)
		begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// One host command, then two cycles for outputs to follow
	task automatic cmd(input uefc_op_t op, input logic [1:0] ch, input logic [2:0] a,
		input logic [15:0] d);
		int n;
		n = 0;
		cmd_op <= op;
		cmd_chan <= ch;
		cmd_addr <= a;
		cmd_data <= d;
		cmd_valid <= 1'b1;
		do
			@(posedge clk_i);
		while (cmd_ready !== 1'b1);
		cmd_valid <= 1'b0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (done !== 1'b1 && n < 200);
		chk("done", 1'b1, done);
		last_err = err;
		last_rd = rdata;
		idle(2);
	endtask : cmd

	task automatic wr(input int ch, input logic [2:0] a, input logic [7:0] d);
		cmd(OP_WRITE, 2'(ch), a, {8'h00, d});
	endtask : wr

	// Ready summary with every channel on the reset trigger of 8
	function automatic logic [7:0] ready_exp();
		logic [7:0] r;
		for (int c = 0; c < 4; c++)
		begin
			r[c] = tx_space[c] >= 7'd8;
			r[c + 4] = rx_level[c] > 7'd8 || rx_timeout[c];
		end
		return r;
	endfunction : ready_exp

	task automatic summarize();
		if (error_cnt == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : summarize

	// Watchdog
	initial
	begin
		idle(20000);
		error_cnt++;
		summarize();
	end

	// Main sequence
	initial
	begin
		void'($urandom(63));
		idle(12);
		sys_rst_i <= 1'b0;
		idle(3);
		tx_space[0] <= 7'd8;
		rx_level[0] <= 7'd8;
		for (int c = 1; c < 4; c++)
		begin
			tx_space[c] <= 7'($urandom_range(64));
			rx_level[c] <= 7'($urandom_range(64));
			rx_timeout[c] <= 1'($urandom);
		end
		wr(1, 3'h4, 8'h06);
		idle(4);
		cmd(OP_READ, 2'h1, 3'h7, 16'h0000);
		chk("ready_summary", ready_exp(), last_rd);
		chk("rts_n", 1'b0, rts_n[1]);
		// Loopback hides the summary; access is closed so the read returns 00
		wr(1, 3'h4, 8'h16);
		cmd(OP_READ, 2'h1, 3'h7, 16'h0000);
		chk("ready_hidden", 8'h00, last_rd);
		wr(1, 3'h4, 8'h00);
		// Divisor per channel, corner values first
		dv[0] = 16'h0001;
		dv[1] = 16'hffff;
		dv[2] = 16'($urandom);
		dv[3] = 16'($urandom);
		for (int c = 0; c < 4; c++)
			cmd(OP_SET_DIV, 2'(c), 3'h0, dv[c]);
		for (int c = 0; c < 4; c++)
			chk("divisor", dv[c], baud[c]);
		// Sleep bit gated, then sleep blocking the divisor
		wr(2, 3'h1, 8'h10);
		cmd(OP_SET_DIV, 2'h2, 3'h0, 16'h1234);
		chk("divisor", 16'h1234, baud[2]);
		wr(1, 3'h3, 8'hbf);
		wr(1, 3'h2, 8'h10);
		wr(1, 3'h3, 8'h00);
		wr(1, 3'h1, 8'h10);
		cmd(OP_SET_DIV, 2'h1, 3'h0, 16'h5a5a);
		chk("divisor", 16'hffff, baud[1]);
		// Every software flow mode
		wr(3, 3'h3, 8'hbf);
		for (int m = 0; m < 16; m++)
		begin
			wr(3, 3'h2, 8'(m));
			chk("flow_mode", 16'(m), sw_mode[3]);
		end
		// Start character written and read back under the enhanced code
		v = 8'($urandom);
		wr(3, 3'h4, v);
		cmd(OP_READ, 2'h3, 3'h4, 16'h0000);
		chk("start_one", v, last_rd);
		// Clear-to-send halt and special character
		wr(3, 3'h2, 8'ha0);
		wr(3, 3'h7, 8'h5c);
		wr(3, 3'h3, 8'h00);
		cts_n[3] <= 1'b1;
		idle(5);
		chk("tx_halt", 1'b1, tx_halt[3]);
		cts_n[3] <= 1'b0;
		cts_n[2] <= 1'b1;
		idle(5);
		chk("tx_halt", 4'h0, tx_halt);
		for (int k = 0; k < 2; k++)
		begin
			rx_char[3] <= 8'h5c ^ 8'(1 - k);
			rx_valid[3] <= 1'b1;
			idle(1);
			rx_valid[3] <= 1'b0;
			idle(3);
			chk("special", 16'(k), special[3]);
		end
		cmd(OP_READ, 2'h3, 3'h2, 16'h0000);
		chk("id_special", 1'b1, last_rd[4]);
		chk("special", 1'b0, special[3]);
		// Thresholds and automatic request-to-send
		cmd(OP_SET_LEVEL, 2'h0, 3'h6, 16'h0044);
		chk("refused", 1'b1, last_err);
		cmd(OP_SET_LEVEL, 2'h0, 3'h6, 16'h002a);
		chk("refused", 1'b0, last_err);
		wr(0, 3'h3, 8'hbf);
		wr(0, 3'h2, 8'h40);
		wr(0, 3'h3, 8'h00);
		wr(0, 3'h6, 8'h11);
		for (int k = 0; k < 7; k++)
		begin
			rx_level[0] <= lv[k];
			idle(4);
			chk("rts_n", rs[k], rts_n[0]);
		end
		// Trigger levels and their fallback
		v = {4'($urandom_range(15, 1)), 4'($urandom_range(15, 1))};
		cmd(OP_SET_LEVEL, 2'h2, 3'h7, {8'h00, v});
		chk("rx_trig", {v[7:4], 2'b00}, rx_trig[2]);
		chk("tx_trig", {v[3:0], 2'b00}, tx_trig[2]);
		wr(2, 3'h7, 8'h11);
		chk("rx_trig", {v[7:4], 2'b00}, rx_trig[2]);
		cmd(OP_SET_LEVEL, 2'h2, 3'h7, 16'h0050);
		chk("rx_trig", 7'd20, rx_trig[2]);
		chk("tx_trig", 7'd8, tx_trig[2]);
		cmd(OP_SET_LEVEL, 2'h2, 3'h7, 16'h0003);
		chk("rx_trig", 7'd8, rx_trig[2]);
		chk("tx_trig", 7'd12, tx_trig[2]);
		// Fallback from fifo_control: receive select free, transmit select gated
		wr(2, 3'h2, 8'hf0);
		chk("rx_trig", 7'd60, rx_trig[2]);
		cmd(OP_SET_LEVEL, 2'h2, 3'h7, 16'h0000);
		chk("tx_trig", 7'd8, tx_trig[2]);
		chk("rx_trig", 7'd60, rx_trig[2]);
		summarize();
	end
endmodule : uart_enhanced_flow_config_bench

// File: uefc_dev.sv
// Device end: per-channel configuration registers of a quad UART.
// Assumes bus strobes come from logic on clk_i; clear-to-send pins are async.
// What this block does
// - Enhanced bits 3:0 select software flow mode
// - Enhanced bit 4 gates protected control bits
// - Special detect flags matches with stop two
// - Auto request-to-send follows halt/restore thresholds
// - Auto clear-to-send high halts transmitter
// - Two latches form sixteen-bit baud divisor
// - Divisor writes blocked while sleep enabled
// - Threshold holds halt and restore levels
// - Threshold writable with write enable and access
// - Host keeps halt above restore
// - Trigger register holds transmit and receive levels
// - Trigger register writable under same enables
// - Zero trigger field falls back to FIFO control
// - Ready low nibble shows transmit space status
// - Ready high nibble shows receive level status
// - Ready register read at seven when enabled
// - Host sets divisor through line code sequence
// - Enhanced code maps feature and character registers
// - Host opens access before writing thresholds
// - Offset seven writes trigger register when enabled
// - Line bit seven maps divisor latches
module uefc_dev
	import uefc_pkg::*;
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	uefc_if.dev bus,
	input wire logic [NCH-1:0] rx_valid_i,
	input wire logic [NCH-1:0][7:0] rx_char_i,
	input wire logic [NCH-1:0][LVL_W-1:0] rx_level_i,
	input wire logic [NCH-1:0][LVL_W-1:0] tx_space_i,
	input wire logic [NCH-1:0] rx_timeout_i,
	input wire logic [NCH-1:0] cts_n_i,
	output logic [NCH-1:0] rts_n_o,
	output logic [NCH-1:0] tx_halt_o,
	output logic [NCH-1:0] special_char_o,
	output logic [NCH-1:0][3:0] sw_flow_mode_o,
	output logic [NCH-1:0][15:0] baud_divisor_o,
	output logic [NCH-1:0][LVL_W-1:0] rx_trig_o,
	output logic [NCH-1:0][LVL_W-1:0] tx_trig_o
);
	logic [NCH-1:0][7:0] div_lo, div_hi, enh, line, modem, imask, fctl;
	logic [NCH-1:0][7:0] start1, start2, stop1, stop2, thresh, trig;
	logic [NCH-1:0] cts_s1, cts_s2, rts_hold, tx_rdy, rx_rdy;
	uefc_sel_t sel_w [NCH];
	uefc_sel_t sel_r;
	logic [1:0] rd_ch;
	logic wr_any, rd_any, any_cs;
	logic [7:0] rd_val, wd;

	// Address decode under the line and modem access codes
	function automatic uefc_sel_t decode(input logic [7:0] l, input logic [7:0] m,
		input logic [7:0] e, input logic [2:0] a, input logic rd);
		uefc_sel_t s;
		logic acc;
		s = SEL_NONE;
		acc = e[ENH_WE] & m[MODEM_ACC];
		if (a == OFS_LINE)
			s = SEL_LINE;
		else if (l == LINE_ENH_CODE)
		begin
			case (a)
				OFS_DIV_LO: s = SEL_DIV_LO;
				OFS_DIV_HI: s = SEL_DIV_HI;
				OFS_ENH: s = SEL_ENH;
				OFS_START1: s = SEL_START1;
				OFS_START2: s = SEL_START2;
				OFS_STOP1: s = SEL_STOP1;
				OFS_STOP2: s = SEL_STOP2;
				default: s = SEL_NONE;
			endcase
		end
		else if (l[LINE_DLAB] && (a == OFS_DIV_LO))
			s = SEL_DIV_LO;
		else if (l[LINE_DLAB] && (a == OFS_DIV_HI))
			s = SEL_DIV_HI;
		else
		begin
			case (a)
				OFS_IMASK: s = SEL_IMASK;
				OFS_FCTL: s = SEL_FCTL;
				OFS_MODEM: s = SEL_MODEM;
				OFS_THRESH: s = acc ? SEL_THRESH : SEL_NONE;
				OFS_TRIG:
				begin
					if (rd && m[MODEM_RDY] && !m[MODEM_LOOP])
						s = SEL_READY;
					else
						s = acc ? SEL_TRIG : SEL_NONE;
				end
				default: s = SEL_NONE;
			endcase
		end
		return s;
	endfunction : decode

	// Keep protected bits unless the write enable is set
	function automatic logic [7:0] gated(input logic [7:0] old, input logic [7:0] d,
		input logic [7:0] mask, input logic we);
		return we ? d : ((old & mask) | (d & ~mask));
	endfunction : gated

	// Trigger from register field, or fifo_control fallback when zero
	function automatic logic [LVL_W-1:0] level(input logic [3:0] f, input logic [1:0] fc,
		input logic [27:0] tab);
		return (f != 4'h0) ? {1'b0, f, 2'b00} : tab[fc * LVL_W +: LVL_W];
	endfunction : level

	// Strobes and read-channel pick, lowest selected channel wins
	assign wr_any = !bus.wr_n;
	assign rd_any = !bus.rd_n;
	assign any_cs = |(~bus.cs_n);
	assign wd = bus.bus_d;
	assign rd_ch = !bus.cs_n[0] ? 2'd0 : (!bus.cs_n[1] ? 2'd1 : (!bus.cs_n[2] ? 2'd2 : 2'd3));
	assign sel_r = decode(line[rd_ch], modem[rd_ch], enh[rd_ch], bus.addr, 1'b1);

	// Read multiplexer
	always_comb
	begin
		case (sel_r)
			SEL_DIV_LO: rd_val = div_lo[rd_ch];
			SEL_DIV_HI: rd_val = div_hi[rd_ch];
			SEL_IMASK: rd_val = imask[rd_ch];
			SEL_FCTL: rd_val = {{2{fctl[rd_ch][FCTL_EN]}}, 1'b0, special_char_o[rd_ch],
				3'b000, !special_char_o[rd_ch]};
			SEL_LINE: rd_val = line[rd_ch];
			SEL_MODEM: rd_val = modem[rd_ch];
			SEL_ENH: rd_val = enh[rd_ch];
			SEL_START1: rd_val = start1[rd_ch];
			SEL_START2: rd_val = start2[rd_ch];
			SEL_STOP1: rd_val = stop1[rd_ch];
			SEL_STOP2: rd_val = stop2[rd_ch];
			SEL_THRESH: rd_val = thresh[rd_ch];
			SEL_TRIG: rd_val = trig[rd_ch];
			SEL_READY: rd_val = {rx_rdy, tx_rdy};
			default: rd_val = 8'h00;
		endcase
	end

	// Read data drive, one cycle after the read strobe
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			bus.dev_oe <= 1'b0;
			bus.dev_d <= REG_RST;
		end
		else
		begin
			bus.dev_oe <= rd_any && any_cs;
			if (rd_any && any_cs)
				bus.dev_d <= rd_val;
		end
	end

	genvar g;
	for (g = 0; g < NCH; g++)
	begin : g_ch
		assign sel_w[g] = decode(line[g], modem[g], enh[g], bus.addr, 1'b0);

		// Register writes of this channel alone
		always_ff @(posedge clk_i)
		begin
			if (sys_rst_i)
			begin
				{div_lo[g], div_hi[g], enh[g], line[g], modem[g], imask[g], fctl[g]} <=
					{7{REG_RST}};
				{start1[g], start2[g], stop1[g], stop2[g], thresh[g], trig[g]} <= {6{REG_RST}};
			end
			else if (wr_any && !bus.cs_n[g])
			begin
				case (sel_w[g])
					SEL_DIV_LO: if (!imask[g][IMASK_SLEEP]) div_lo[g] <= wd;
					SEL_DIV_HI: if (!imask[g][IMASK_SLEEP]) div_hi[g] <= wd;
					SEL_IMASK: imask[g] <= gated(imask[g], wd, IMASK_GATED, enh[g][ENH_WE]);
					SEL_FCTL: fctl[g] <= gated(fctl[g], wd, FCTL_GATED, enh[g][ENH_WE]);
					SEL_MODEM: modem[g] <= gated(modem[g], wd, MODEM_GATED, enh[g][ENH_WE]);
					SEL_LINE: line[g] <= wd;
					SEL_ENH: enh[g] <= wd;
					SEL_START1: start1[g] <= wd;
					SEL_START2: start2[g] <= wd;
					SEL_STOP1: stop1[g] <= wd;
					SEL_STOP2: stop2[g] <= wd;
					SEL_THRESH: thresh[g] <= wd;
					SEL_TRIG: trig[g] <= wd;
					default: ;
				endcase
			end
		end

		// Pin synchroniser, flow outputs, triggers and ready bits
		always_ff @(posedge clk_i)
		begin
			if (sys_rst_i)
			begin
				cts_s1[g] <= 1'b0;
				cts_s2[g] <= 1'b0;
				rts_hold[g] <= 1'b0;
				rts_n_o[g] <= 1'b1;
				tx_halt_o[g] <= 1'b0;
				special_char_o[g] <= 1'b0;
				sw_flow_mode_o[g] <= 4'h0;
				baud_divisor_o[g] <= 16'h0000;
				rx_trig_o[g] <= '0;
				tx_trig_o[g] <= '0;
				tx_rdy[g] <= 1'b0;
				rx_rdy[g] <= 1'b0;
			end
			else
			begin
				cts_s1[g] <= cts_n_i[g];
				cts_s2[g] <= cts_s1[g];
				if (rx_level_i[g] >= {1'b0, thresh[g][3:0], 2'b00})
					rts_hold[g] <= 1'b1;
				else if (rx_level_i[g] <= {1'b0, thresh[g][7:4], 2'b00})
					rts_hold[g] <= 1'b0;
				rts_n_o[g] <= enh[g][ENH_ART] ? rts_hold[g] : !modem[g][MODEM_RTS];
				tx_halt_o[g] <= enh[g][ENH_ACT] && cts_s2[g];
				if (enh[g][ENH_SPECIAL] && rx_valid_i[g] && (rx_char_i[g] == stop2[g]))
					special_char_o[g] <= 1'b1;
				else if (rd_any && !bus.cs_n[g] && (rd_ch == g) && (sel_r == SEL_FCTL))
					special_char_o[g] <= 1'b0;
				sw_flow_mode_o[g] <= enh[g][3:0];
				baud_divisor_o[g] <= {div_hi[g], div_lo[g]};
				rx_trig_o[g] <= level(trig[g][7:4], fctl[g][FCTL_RXT +: 2], RX_FCTL_LVLS);
				tx_trig_o[g] <= level(trig[g][3:0], fctl[g][FCTL_TXT +: 2], TX_FCTL_LVLS);
				tx_rdy[g] <= tx_space_i[g] >= tx_trig_o[g];
				rx_rdy[g] <= (rx_level_i[g] > rx_trig_o[g]) || rx_timeout_i[g];
			end
		end
	end
endmodule : uefc_dev

// File: uefc_host.sv
// Host end: turns user commands into bus cycles, including set-up sequences.
// Assumes the device sits on the same clock and answers reads one cycle late.
module uefc_host
	import uefc_pkg::*;
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	uefc_if.host bus,
	input wire logic cmd_valid_i,
	output logic cmd_ready_o,
	input wire uefc_op_t cmd_op_i,
	input wire logic [1:0] cmd_chan_i,
	input wire logic [2:0] cmd_addr_i,
	input wire logic [15:0] cmd_data_i,
	output logic done_o,
	output logic err_o,
	output logic [7:0] rdata_o
);
	typedef enum {H_IDLE, H_ISSUE, H_STROBE, H_CAPT} uefc_hst_t;
	uefc_hst_t st;
	uefc_op_t op;
	logic [3:0] n;
	logic [1:0] chan;
	logic [2:0] addr_q;
	logic [15:0] val;
	logic [7:0] t1, t2, t3;
	uefc_step_t cur;
	logic bad_order;

	// One bus step of the running command
	function automatic uefc_step_t step_of(input uefc_op_t o, input logic [3:0] k,
		input logic [2:0] a, input logic [15:0] v, input logic [7:0] s1,
		input logic [7:0] s2, input logic [7:0] s3);
		uefc_step_t s;
		s = '{last: 1'b1, wr: 1'b0, addr: a, data: v[7:0], save: 2'd0};
		case (o)
			OP_WRITE: s.wr = 1'b1;
			OP_SET_DIV:
			begin
				s.last = (k == 4'd4);
				s.wr = (k != 4'd0);
				case (k)
					4'd0: {s.addr, s.save} = {OFS_LINE, 2'd1};
					4'd1: {s.addr, s.data} = {OFS_LINE, LINE_DIV_CODE};
					4'd2: {s.addr, s.data} = {OFS_DIV_LO, v[7:0]};
					4'd3: {s.addr, s.data} = {OFS_DIV_HI, v[15:8]};
					default: {s.addr, s.data} = {OFS_LINE, s1};
				endcase
			end
			OP_SET_LEVEL:
			begin
				s.last = (k == 4'd11);
				s.wr = !((k == 4'd0) || (k == 4'd2) || (k == 4'd5));
				case (k)
					4'd0: {s.addr, s.save} = {OFS_LINE, 2'd1};
					4'd1: {s.addr, s.data} = {OFS_LINE, LINE_ENH_CODE};
					4'd2: {s.addr, s.save} = {OFS_ENH, 2'd2};
					4'd3: {s.addr, s.data} = {OFS_ENH, s2 | ENH_WE_SET};
					4'd4: {s.addr, s.data} = {OFS_LINE, LINE_NORMAL};
					4'd5: {s.addr, s.save} = {OFS_MODEM, 2'd3};
					4'd6: {s.addr, s.data} = {OFS_MODEM, s3 | MODEM_ACC_SET};
					4'd7: s.addr = a;
					4'd8: {s.addr, s.data} = {OFS_MODEM, s3};
					4'd9: {s.addr, s.data} = {OFS_LINE, LINE_ENH_CODE};
					4'd10: {s.addr, s.data} = {OFS_ENH, s2};
					default: {s.addr, s.data} = {OFS_LINE, s1};
				endcase
			end
			default: ;
		endcase
		return s;
	endfunction : step_of

	assign cur = step_of(op, n, addr_q, val, t1, t2, t3);
	assign cmd_ready_o = (st == H_IDLE);
	// Halt level must exceed restore level before it is written
	assign bad_order = (cmd_op_i == OP_SET_LEVEL) && (cmd_addr_i == OFS_THRESH)
		&& (cmd_data_i[3:0] <= cmd_data_i[7:4]);

	// Command sequencer and bus drive
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			st <= H_IDLE;
			op <= OP_READ;
			{n, chan, addr_q, val, t1, t2, t3} <= '0;
			{done_o, err_o, rdata_o} <= '0;
			bus.cs_n <= 4'hf;
			bus.addr <= 3'h0;
			bus.wr_n <= 1'b1;
			bus.rd_n <= 1'b1;
			bus.host_d <= 8'h00;
			bus.host_oe <= 1'b0;
		end
		else
		begin
			done_o <= 1'b0;
			err_o <= 1'b0;
			case (st)
				H_IDLE:
				begin
					if (cmd_valid_i && bad_order)
						{done_o, err_o} <= 2'b11;
					else if (cmd_valid_i)
					begin
						op <= cmd_op_i;
						{chan, addr_q, val, n} <= {cmd_chan_i, cmd_addr_i, cmd_data_i, 4'd0};
						st <= H_ISSUE;
					end
				end
				H_ISSUE:
				begin
					bus.cs_n <= ~(4'h1 << chan);
					bus.addr <= cur.addr;
					bus.wr_n <= !cur.wr;
					bus.rd_n <= cur.wr;
					bus.host_d <= cur.data;
					bus.host_oe <= cur.wr;
					st <= H_STROBE;
				end
				H_STROBE:
				begin
					{bus.cs_n, bus.wr_n, bus.rd_n, bus.host_oe} <= {4'hf, 3'b110};
					if (!cur.wr)
						st <= H_CAPT;
					else if (cur.last)
					begin
						done_o <= 1'b1;
						st <= H_IDLE;
					end
					else
					begin
						n <= n + 4'd1;
						st <= H_ISSUE;
					end
				end
				H_CAPT:
				begin
					rdata_o <= bus.bus_d;
					case (cur.save)
						2'd1: t1 <= bus.bus_d;
						2'd2: t2 <= bus.bus_d;
						2'd3: t3 <= bus.bus_d;
						default: ;
					endcase
					if (cur.last)
					begin
						done_o <= 1'b1;
						st <= H_IDLE;
					end
					else
					begin
						n <= n + 4'd1;
						st <= H_ISSUE;
					end
				end
				default: st <= H_IDLE;
			endcase
		end
	end
endmodule : uefc_host

// File: uefc_if.sv
// Parallel register bus between the host end and the four-channel device.
// Assumes both ends run on the same clock; the shared data lines resolve here.
interface uefc_if;
	logic [3:0] cs_n;
	logic [2:0] addr;
	logic wr_n;
	logic rd_n;
	logic [7:0] host_d;
	logic host_oe;
	logic [7:0] dev_d;
	logic dev_oe;
	wire logic [7:0] bus_d;

	// Shared data lines, pulled high when nobody drives
	assign bus_d = dev_oe ? dev_d : (host_oe ? host_d : 8'hff);

	modport host (output cs_n, output addr, output wr_n, output rd_n,
		output host_d, output host_oe, input bus_d);
	modport dev (input cs_n, input addr, input wr_n, input rd_n,
		output dev_d, output dev_oe, input bus_d);
endinterface : uefc_if

// File: uefc_pkg.sv
// Constants and types shared by both ends of the UART configuration port.
// Assumes one clock domain and four channels sharing one register bus.
package uefc_pkg;
	localparam int NCH = 4;
	localparam int LVL_W = 7;
	// Register offsets on the three address lines
	localparam logic [2:0] OFS_DIV_LO = 3'h0;
	localparam logic [2:0] OFS_DIV_HI = 3'h1;
	localparam logic [2:0] OFS_IMASK = 3'h1;
	localparam logic [2:0] OFS_ENH = 3'h2;
	localparam logic [2:0] OFS_FCTL = 3'h2;
	localparam logic [2:0] OFS_LINE = 3'h3;
	localparam logic [2:0] OFS_MODEM = 3'h4;
	localparam logic [2:0] OFS_START1 = 3'h4;
	localparam logic [2:0] OFS_START2 = 3'h5;
	localparam logic [2:0] OFS_STOP1 = 3'h6;
	localparam logic [2:0] OFS_THRESH = 3'h6;
	localparam logic [2:0] OFS_STOP2 = 3'h7;
	localparam logic [2:0] OFS_TRIG = 3'h7;
	// Access codes and set masks
	localparam logic [7:0] LINE_ENH_CODE = 8'hbf;
	localparam logic [7:0] LINE_DIV_CODE = 8'h80;
	localparam logic [7:0] LINE_NORMAL = 8'h00;
	localparam logic [7:0] ENH_WE_SET = 8'h10;
	localparam logic [7:0] MODEM_ACC_SET = 8'h40;
	localparam logic [7:0] REG_RST = 8'h00;
	// Bits protected by the enhanced write enable
	localparam logic [7:0] IMASK_GATED = 8'hf0;
	localparam logic [7:0] FCTL_GATED = 8'h30;
	localparam logic [7:0] MODEM_GATED = 8'he0;
	// Field positions
	localparam int LINE_DLAB = 7;
	localparam int ENH_WE = 4;
	localparam int ENH_SPECIAL = 5;
	localparam int ENH_ART = 6;
	localparam int ENH_ACT = 7;
	localparam int MODEM_RTS = 1;
	localparam int MODEM_RDY = 2;
	localparam int MODEM_LOOP = 4;
	localparam int MODEM_ACC = 6;
	localparam int IMASK_SLEEP = 4;
	localparam int FCTL_EN = 0;
	localparam int FCTL_RXT = 6;
	localparam int FCTL_TXT = 4;
	// Fallback trigger levels picked by fifo_control, entry 0 lowest
	localparam logic [27:0] RX_FCTL_LVLS = {7'h3c, 7'h38, 7'h10, 7'h08};
	localparam logic [27:0] TX_FCTL_LVLS = {7'h38, 7'h20, 7'h10, 7'h08};

	typedef enum {
		SEL_NONE, SEL_DIV_LO, SEL_DIV_HI, SEL_IMASK, SEL_FCTL, SEL_LINE, SEL_MODEM, SEL_ENH,
		SEL_START1, SEL_START2, SEL_STOP1, SEL_STOP2, SEL_THRESH, SEL_TRIG, SEL_READY
	} uefc_sel_t;

	typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_SET_DIV, OP_SET_LEVEL} uefc_op_t;

	typedef struct packed {
		logic last;
		logic wr;
		logic [2:0] addr;
		logic [7:0] data;
		logic [1:0] save;
	} uefc_step_t;
endpackage : uefc_pkg

// File: uefc_properties.sv
// Protocol checks on the register bus between host end and device end.
// Assumes the interface signals arrive as plain inputs on one clock.
module uefc_properties (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [3:0] cs_n,
	input wire logic [2:0] addr,
	input wire logic wr_n,
	input wire logic rd_n,
	input wire logic [7:0] host_d,
	input wire logic host_oe,
	input wire logic [7:0] dev_d,
	input wire logic dev_oe,
	input wire logic [7:0] bus_d
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);

	// Read answer timing and data path
	a_read_answer: assert property (!rd_n |=> dev_oe)
		else $error("read strobe not answered next cycle");
	a_answer_cause: assert property (dev_oe |-> !$past(rd_n) && $past(cs_n) != 4'hf)
		else $error("device drove data without a read");
	a_oe_pulse: assert property (dev_oe |=> !dev_oe)
		else $error("device data enable longer than one cycle");
	a_read_data: assert property (dev_oe |-> bus_d == dev_d)
		else $error("bus lines differ from device data");
	a_read_gap: assert property (!rd_n |=> (rd_n && wr_n)[*2])
		else $error("access too soon after a read");
	a_data_hold: assert property ($past(rd_n) |-> $stable(dev_d))
		else $error("device data changed without a read");
	// Write strobes and bus ownership
	a_write_pulse: assert property (!wr_n |=> wr_n && rd_n)
		else $error("write strobe not a lone pulse");
	a_write_drive: assert property ((host_oe == !wr_n) && (wr_n || bus_d == host_d))
		else $error("host drive does not match write strobe");
	a_no_clash: assert property (!(host_oe && dev_oe) && !(!wr_n && !rd_n))
		else $error("both ends drive or both strobes low");
	a_chan_select: assert property ((!wr_n || !rd_n) |-> cs_n != 4'hf)
		else $error("strobe with no channel selected");

	// Main traffic seen
	c_thresh_wr: cover property (!wr_n && addr == 3'h6);
	c_ready_rd: cover property (!rd_n && addr == 3'h7);
	c_answer: cover property (dev_oe);
endmodule : uefc_properties
